// [design/clock_channel_defs.vh]
`ifndef CLOCK_CHANNEL_DEFS_VH
`define CLOCK_CHANNEL_DEFS_VH

// register byte offsets; channel c sits at the channel offsets plus c times the stride
`define ADDR_W 10
`define CH_DRIVE_OFFSET 10'h196
`define CH_DIV_LOW_OFFSET 10'h197
`define CH_PHASE_DIV_HIGH_OFFSET 10'h198
`define CH_STRIDE 10'h003
`define AUX_OUT_CTRL_OFFSET 10'h1BA
`define AUX_CHAN_CTRL_OFFSET 10'h1BB

// field positions
`define DRV_INVERT_BIT 7
`define DRV_MODE_MSB 3
`define DRV_MODE_LSB 0
`define PH_FIELD_MSB 7
`define PH_FIELD_LSB 2
`define DIV_HIGH_MSB 1
`define DIV_HIGH_LSB 0
`define AUX_STRENGTH_BIT 4
`define AUX_DIV_MSB 3
`define AUX_DIV_LSB 0
`define AUX_PWRDN_BIT 7
`define AUX_ROUTE_CH1_BIT 1
`define AUX_ROUTE_CH0_BIT 0

// reset values
`define CH_DRIVE_RESET 8'h00
`define CH_DIV_LOW_RESET 8'h00
`define CH_PHASE_DIV_HIGH_RESET 8'h00
`define AUX_OUT_CTRL_RESET 8'h01
`define AUX_CHAN_CTRL_RESET 8'h00

// driver mode codes
`define MODE_TRISTATE 4'h0
`define MODE_PECL_8MA 4'h1
`define MODE_LVDS_3P5MA 4'h2
`define MODE_LVDS_7MA 4'h3
`define MODE_HIGH_CURRENT_TERMINATED 4'h4
`define MODE_LOW_CURRENT_TERMINATED 4'h5
`define MODE_CMOS_BOTH_TRUE 4'h6
`define MODE_CMOS_TRUE_COMP 4'h7
`define MODE_CMOS_TRUE_P_ONLY 4'h8
`define MODE_CMOS_TRUE_N_ONLY 4'h9
`define MODE_CMOS_ALL_HIGHZ 4'hA
`define MODE_CMOS_BOTH_COMP 4'hB
`define MODE_CMOS_COMP_TRUE 4'hC
`define MODE_CMOS_COMP_P_ONLY 4'hD
`define MODE_CMOS_COMP_N_ONLY 4'hE
`define MODE_TRISTATE_ALT 4'hF

// auxiliary divider codes and their half-period toggle limits
`define AUX_DIV1 4'h0
`define AUX_DIV2 4'h1
`define AUX_DIV4 4'h2
`define AUX_DIV8 4'h4
`define AUX_DIV16 4'h8
`define AUX_LIM1 4'h0
`define AUX_LIM2 4'h1
`define AUX_LIM4 4'h3
`define AUX_LIM8 4'h7
`define AUX_LIM16 4'hF

`endif

// [design/channel_divider.v]
`timescale 1ns/1ps
`default_nettype none
`include "clock_channel_defs.vh"

// divide-by-(setting+1) with a delayed start after sync release, in half input periods
module channel_divider #(
    parameter DIV_W = 10,
    parameter PHASE_W = 6
) (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire half_tick,
    input wire sync_hold,
    input wire [DIV_W-1:0] div_setting,
    input wire [PHASE_W-1:0] phase,
    output reg div_clk
);
    localparam [2:0] ST_HOLD = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    reg [2:0] state;
    reg [DIV_W-1:0] count;
    wire [DIV_W-1:0] phase_wide = {{(DIV_W-PHASE_W){1'b0}}, phase};
    wire [DIV_W-1:0] phase_last = phase_wide - {{(DIV_W-1){1'b0}}, 1'b1};

    // every half input period counts once, so the output toggles after setting+1 ticks
    // and the duty stays even for odd divides too
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_HOLD;
            count <= {DIV_W{1'b0}};
            div_clk <= 1'b0;
        end else if (ce) begin
            if (sync_hold) begin
                state <= ST_HOLD;
                count <= {DIV_W{1'b0}};
                div_clk <= 1'b0;
            end else begin
                case (state)
                    ST_HOLD: begin
                        count <= {DIV_W{1'b0}};
                        state <= (phase == {PHASE_W{1'b0}}) ? ST_RUN : ST_DELAY; // [R07]
                    end
                    ST_DELAY: begin
                        // wait the programmed half periods before the first edge
                        if (half_tick) begin
                            if (count == phase_last) begin
                                state <= ST_RUN; // [R08]
                                count <= {DIV_W{1'b0}};
                            end else begin
                                count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
                            end
                        end
                    end
                    ST_RUN: begin
                        if (half_tick) begin
                            if (count == div_setting) begin
                                div_clk <= ~div_clk; // [R05]
                                count <= {DIV_W{1'b0}};
                            end else begin
                                count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
                            end
                        end
                    end
                    default: begin
                        state <= ST_HOLD;
                        count <= {DIV_W{1'b0}};
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// [design/clock_channel_output.v]
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "clock_channel_defs.vh"

// What this block does
// R01: mode codes 0 to 9 pick tristate, differential standards, or CMOS true variants
// R02: drive register bit 7 inverts the clock leaving the channel divider
// R03: code A all high-Z, B both complement, C plus complement minus true
// R04: code D plus complement only, E minus complement only, F tristate
// R05: channel divider divides by the 10-bit setting plus one
// R06: divider low byte in one register, bits 9:8 in the next register's bits 1:0
// R07: after sync the divider starts at a phase of 6-bit half-period steps
// R08: phase delay counts half input periods from sync release before first edge
// R09: auxiliary output strength bit 4: one weak, zero strong
// R10: auxiliary divider code picks divide by 1, 2, 4, 8 or 16; default 2
// R11: software writes only the five listed auxiliary divider codes
// R12: auxiliary channel control bit 7 powers down the auxiliary driver
// R13: bits 1 and 0 route the oscillator clock to channels 1 and 0 dividers
module clock_channel_output #(
    parameter NUM_CHANNELS = 6,
    parameter DIV_W = 10,
    parameter PHASE_W = 6
) (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [`ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire vco_half_tick,
    input wire osc_half_tick,
    input wire sync_hold,
    output reg [NUM_CHANNELS-1:0] out_p,
    output reg [NUM_CHANNELS-1:0] out_n,
    output reg [NUM_CHANNELS-1:0] oe_p,
    output reg [NUM_CHANNELS-1:0] oe_n,
    output reg [NUM_CHANNELS-1:0] diff_enable,
    output reg [4*NUM_CHANNELS-1:0] drive_mode,
    output reg cleanup_loop_clock_pin,
    output reg cleanup_loop_clock_oe,
    output reg cleanup_loop_weak_drive
);
    // pin pattern: {p_true, p_comp, p_en, n_true, n_comp, n_en, diff}
    // differential codes drive p true and n complement
    function [6:0] pin_pattern;
        input [3:0] mode;
        begin
            case (mode)
                `MODE_PECL_8MA, `MODE_LVDS_3P5MA, `MODE_LVDS_7MA,
                `MODE_HIGH_CURRENT_TERMINATED, `MODE_LOW_CURRENT_TERMINATED:
                    pin_pattern = 7'b1010111; // [R01]
                `MODE_CMOS_BOTH_TRUE: pin_pattern = 7'b1011010; // [R01]
                `MODE_CMOS_TRUE_COMP: pin_pattern = 7'b1010110; // [R01]
                `MODE_CMOS_TRUE_P_ONLY: pin_pattern = 7'b1010000; // [R01]
                `MODE_CMOS_TRUE_N_ONLY: pin_pattern = 7'b0001010; // [R01]
                `MODE_CMOS_BOTH_COMP: pin_pattern = 7'b0110110; // [R03]
                `MODE_CMOS_COMP_TRUE: pin_pattern = 7'b0111010; // [R03]
                `MODE_CMOS_COMP_P_ONLY: pin_pattern = 7'b0110000; // [R04]
                `MODE_CMOS_COMP_N_ONLY: pin_pattern = 7'b0000110; // [R04]
                // tristate, all high-Z and the alternate tristate code
                default: pin_pattern = 7'b0000000; // [R03] [R04]
            endcase
        end
    endfunction

    // toggle limit in half periods for each auxiliary divider code
    function [3:0] aux_limit;
        input [3:0] code;
        begin
            case (code)
                `AUX_DIV2: aux_limit = `AUX_LIM2; // [R10]
                `AUX_DIV4: aux_limit = `AUX_LIM4; // [R10]
                `AUX_DIV8: aux_limit = `AUX_LIM8; // [R10]
                `AUX_DIV16: aux_limit = `AUX_LIM16; // [R10]
                // unlisted codes are not to be written; they fall back to divide by 1
                default: aux_limit = `AUX_LIM1; // [R11]
            endcase
        end
    endfunction

    reg [7:0] aux_loop_output_control;
    reg [7:0] aux_loop_channel_control;
    reg [8*NUM_CHANNELS-1:0] channel_drive;
    reg [8*NUM_CHANNELS-1:0] channel_divider_low;
    reg [8*NUM_CHANNELS-1:0] channel_phase_and_divider_high;
    wire [NUM_CHANNELS-1:0] div_clk;
    reg [3:0] aux_count;
    reg aux_clk;
    reg [7:0] next_rdata;
    integer k;

    wire aux_out_sel = (addr == `AUX_OUT_CTRL_OFFSET);
    wire aux_chan_sel = (addr == `AUX_CHAN_CTRL_OFFSET);

    // auxiliary registers; reset default gives divide by 2
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_loop_output_control <= `AUX_OUT_CTRL_RESET; // [R10]
            aux_loop_channel_control <= `AUX_CHAN_CTRL_RESET;
        end else if (ce && wr) begin
            if (aux_out_sel)
                aux_loop_output_control <= wdata;
            if (aux_chan_sel)
                aux_loop_channel_control <= wdata;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CHANNELS; c = c + 1) begin : g_chan
            // the product is integer wide; only the address bits are kept
            wire [31:0] base_full = c * `CH_STRIDE;
            wire [`ADDR_W-1:0] base = base_full[`ADDR_W-1:0];
            wire drv_sel = (addr == `CH_DRIVE_OFFSET + base);
            wire low_sel = (addr == `CH_DIV_LOW_OFFSET + base);
            wire high_sel = (addr == `CH_PHASE_DIV_HIGH_OFFSET + base);
            wire [7:0] drv = channel_drive[8*c +: 8];
            wire [7:0] ph_reg = channel_phase_and_divider_high[8*c +: 8];
            wire [DIV_W-1:0] setting = {ph_reg[`DIV_HIGH_MSB:`DIV_HIGH_LSB],
                                        channel_divider_low[8*c +: 8]}; // [R06]
            wire [PHASE_W-1:0] phase = ph_reg[`PH_FIELD_MSB:`PH_FIELD_LSB]; // [R07]
            wire route_osc;
            wire half_tick;
            wire chan_clk;
            wire [6:0] pat;

            if (c == 0) begin : g_route0
                assign route_osc = aux_loop_channel_control[`AUX_ROUTE_CH0_BIT];
            end else if (c == 1) begin : g_route1
                assign route_osc = aux_loop_channel_control[`AUX_ROUTE_CH1_BIT];
            end else begin : g_route_none
                assign route_osc = 1'b0;
            end
            // oscillator or VCO-divider clock feeds the divider
            assign half_tick = route_osc ? osc_half_tick : vco_half_tick; // [R13]

            // channel registers
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    channel_drive[8*c +: 8] <= `CH_DRIVE_RESET;
                    channel_divider_low[8*c +: 8] <= `CH_DIV_LOW_RESET;
                    channel_phase_and_divider_high[8*c +: 8] <= `CH_PHASE_DIV_HIGH_RESET;
                end else if (ce && wr) begin
                    if (drv_sel)
                        channel_drive[8*c +: 8] <= wdata;
                    if (low_sel)
                        channel_divider_low[8*c +: 8] <= wdata; // [R06]
                    if (high_sel)
                        channel_phase_and_divider_high[8*c +: 8] <= wdata; // [R06]
                end
            end

            channel_divider #(
                .DIV_W(DIV_W),
                .PHASE_W(PHASE_W)
            ) u_div (
                .clk(clk),
                .resetn(resetn),
                .ce(ce),
                .half_tick(half_tick),
                .sync_hold(sync_hold),
                .div_setting(setting),
                .phase(phase),
                .div_clk(div_clk[c])
            );

            assign chan_clk = div_clk[c] ^ drv[`DRV_INVERT_BIT]; // [R02]
            assign pat = pin_pattern(drv[`DRV_MODE_MSB:`DRV_MODE_LSB]);

            // pins are registered so mode changes never glitch the pads
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    out_p[c] <= 1'b0;
                    out_n[c] <= 1'b0;
                    oe_p[c] <= 1'b0;
                    oe_n[c] <= 1'b0;
                    diff_enable[c] <= 1'b0;
                    drive_mode[4*c +: 4] <= `MODE_TRISTATE;
                end else if (ce) begin
                    out_p[c] <= (pat[6] & chan_clk) | (pat[5] & ~chan_clk); // [R01] [R03] [R04]
                    oe_p[c] <= pat[4];
                    out_n[c] <= (pat[3] & chan_clk) | (pat[2] & ~chan_clk); // [R01] [R03] [R04]
                    oe_n[c] <= pat[1];
                    diff_enable[c] <= pat[0];
                    drive_mode[4*c +: 4] <= drv[`DRV_MODE_MSB:`DRV_MODE_LSB];
                end
            end
        end
    endgenerate

    // auxiliary divider: power-of-two divide of the oscillator clock
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_count <= 4'h0;
            aux_clk <= 1'b0;
        end else if (ce && osc_half_tick) begin
            if (aux_count >= aux_limit(aux_loop_output_control[`AUX_DIV_MSB:`AUX_DIV_LSB])) begin
                aux_clk <= ~aux_clk; // [R10]
                aux_count <= 4'h0;
            end else begin
                aux_count <= aux_count + 4'h1;
            end
        end
    end

    // auxiliary pin; powered down means not driven, the divider keeps running
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cleanup_loop_clock_pin <= 1'b0;
            cleanup_loop_clock_oe <= 1'b0;
            cleanup_loop_weak_drive <= 1'b0;
        end else if (ce) begin
            cleanup_loop_clock_oe <= ~aux_loop_channel_control[`AUX_PWRDN_BIT]; // [R12]
            cleanup_loop_clock_pin <= aux_clk & ~aux_loop_channel_control[`AUX_PWRDN_BIT]; // [R12]
            cleanup_loop_weak_drive <= aux_loop_output_control[`AUX_STRENGTH_BIT]; // [R09]
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        if (aux_out_sel)
            next_rdata = aux_loop_output_control;
        if (aux_chan_sel)
            next_rdata = aux_loop_channel_control;
        for (k = 0; k < NUM_CHANNELS; k = k + 1) begin
            if (addr == `CH_DRIVE_OFFSET + k * `CH_STRIDE)
                next_rdata = channel_drive[8*k +: 8];
            if (addr == `CH_DIV_LOW_OFFSET + k * `CH_STRIDE)
                next_rdata = channel_divider_low[8*k +: 8];
            if (addr == `CH_PHASE_DIV_HIGH_OFFSET + k * `CH_STRIDE)
                next_rdata = channel_phase_and_divider_high[8*k +: 8];
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            rdata <= 8'h00;
        else if (ce)
            rdata <= rd ? next_rdata : 8'h00;
    end
endmodule

`default_nettype wire

// [tb/clock_channel_output_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clock_channel_defs.vh"
// channel 0 pin relations and auxiliary pin control, seen at the top ports
module clock_channel_output_properties #(
    parameter NUM_CHANNELS = 6
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic [NUM_CHANNELS-1:0] out_p,
    input wire logic [NUM_CHANNELS-1:0] out_n,
    input wire logic [NUM_CHANNELS-1:0] oe_p,
    input wire logic [NUM_CHANNELS-1:0] oe_n,
    input wire logic [NUM_CHANNELS-1:0] diff_enable,
    input wire logic [4*NUM_CHANNELS-1:0] drive_mode,
    input wire logic cleanup_loop_clock_pin,
    input wire logic cleanup_loop_clock_oe,
    input wire logic cleanup_loop_weak_drive
);
    // channel 0 mode code as the pad sees it
    wire [3:0] m = drive_mode[3:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_highz_modes:
        assert property ((m == 4'h0 || m == 4'hA || m == 4'hF) |-> !oe_p[0] && !oe_n[0])
        else $error("pin driven in high-Z mode");
    a_in_phase_pair:
        assert property ((m == 4'h6 || m == 4'hB) |-> oe_p[0] && oe_n[0] && out_p[0] == out_n[0])
        else $error("in-phase pins differ");
    a_opposite_pair:
        assert property ((m >= 4'h1 && m <= 4'h5 || m == 4'h7 || m == 4'hC) |-> out_p[0] != out_n[0])
        else $error("opposite pins agree");
    a_single_pin:
        assert property ((m == 4'hD || m == 4'hE) |-> oe_p[0] == (m == 4'hD) && oe_n[0] == (m == 4'hE))
        else $error("wrong single pin driven");
    a_diff_flag:
        assert property (diff_enable[0] == (m >= 4'h1 && m <= 4'h5))
        else $error("differential flag wrong");
    a_mode_copy:
        assert property (wr && addr == `CH_DRIVE_OFFSET |-> ##2 m == $past(wdata[3:0], 2))
        else $error("mode not taken from write");
    a_weak_strength:
        assert property (wr && addr == `AUX_OUT_CTRL_OFFSET |-> ##2 cleanup_loop_weak_drive == $past(wdata[4], 2))
        else $error("strength not taken from write");
    a_power_down:
        assert property (wr && addr == `AUX_CHAN_CTRL_OFFSET |-> ##2 cleanup_loop_clock_oe == !$past(wdata[7], 2))
        else $error("power-down not taken from write");
    a_down_pin_low:
        assert property (!cleanup_loop_clock_oe |-> !cleanup_loop_clock_pin)
        else $error("powered-down pin toggles");
endmodule

bind clock_channel_output clock_channel_output_properties #(
    .NUM_CHANNELS(NUM_CHANNELS)
) clock_channel_output_properties_inst (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .out_p(out_p), .out_n(out_n), .oe_p(oe_p), .oe_n(oe_n), .diff_enable(diff_enable),
    .drive_mode(drive_mode), .cleanup_loop_clock_pin(cleanup_loop_clock_pin),
    .cleanup_loop_clock_oe(cleanup_loop_clock_oe), .cleanup_loop_weak_drive(cleanup_loop_weak_drive)
);
`default_nettype wire

// [tb/clock_load.sv]
`timescale 1ns/1ps
`default_nettype none
// clocked load on one pin: measures the received clock in bench cycles
module clock_load (
    input wire logic clk,
    input wire logic pin,
    input wire logic drv,
    output var int period,
    output var int edges
);
    int cnt;
    logic last;
    initial begin
        cnt = 0;
        last = 1'h0;
        period = 0;
        edges = 0;
    end
    // an undriven pin floats, so edges only count while the pin is driven
    always @(posedge clk) begin
        last <= pin & drv;
        cnt <= cnt + 1;
        if (pin && drv && !last) begin
            period <= cnt + 1;
            cnt <= 0;
            edges <= edges + 1;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_clock_channel_output.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clock_channel_defs.vh"
module tb_clock_channel_output;
    logic clk, resetn, ce, wr, rd, vt, ot, sync_hold;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] wdata;
    wire [7:0] rdata;
    wire [5:0] out_p, out_n, oe_p, oe_n, diff_en;
    wire [23:0] drive_mode;
    wire aux_pin, aux_oe, aux_weak;
    int fail_count, check_count, p0_per, p0_edges, ax_per, ax_edges;
    clock_channel_output clock_channel_output_inst (
        .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .vco_half_tick(vt), .osc_half_tick(ot), .sync_hold(sync_hold),
        .out_p(out_p), .out_n(out_n), .oe_p(oe_p), .oe_n(oe_n), .diff_enable(diff_en),
        .drive_mode(drive_mode), .cleanup_loop_clock_pin(aux_pin),
        .cleanup_loop_clock_oe(aux_oe), .cleanup_loop_weak_drive(aux_weak)
    );
    clock_load clock_load_inst (
        .clk(clk), .pin(out_p[0]), .drv(oe_p[0]), .period(p0_per), .edges(p0_edges)
    );
    clock_load clock_load_aux_inst (
        .clk(clk), .pin(aux_pin), .drv(aux_oe), .period(ax_per), .edges(ax_edges)
    );
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task stop_test;
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // read data is only valid in the cycle right after the strobe
    task rd_chk(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(rdata, e);
    endtask
    // bounded wait for n more rising edges at one load
    task wait_edges(input bit aux, input int n);
        int base, i;
        base = aux ? ax_edges : p0_edges;
        i = 0;
        while ((aux ? ax_edges : p0_edges) < base + n && i < 8000) begin
            @(posedge clk);
            #1 i++;
        end
    endtask
    task t_regs;
        rd_chk(`AUX_OUT_CTRL_OFFSET, 8'h01);
        rd_chk(`AUX_CHAN_CTRL_OFFSET, 8'h00);
        wr_reg(`CH_DIV_LOW_OFFSET, 8'hA5);
        wr_reg(`CH_PHASE_DIV_HIGH_OFFSET, 8'hFE);
        wr_reg(10'h3FF, 8'h5A);
        rd_chk(`CH_DIV_LOW_OFFSET, 8'hA5);
        rd_chk(`CH_PHASE_DIV_HIGH_OFFSET, 8'hFE);
        rd_chk(10'h3FF, 8'h00);
    endtask
    // {p driven, n driven, p complement, n complement}
    function logic [3:0] mode_exp(input logic [3:0] m);
        case (m)
            4'h0, 4'hA, 4'hF: mode_exp = 4'h0;
            4'h6: mode_exp = 4'hC;
            4'h8: mode_exp = 4'h8;
            4'h9: mode_exp = 4'h4;
            4'hB: mode_exp = 4'hF;
            4'hC: mode_exp = 4'hE;
            4'hD: mode_exp = 4'hA;
            4'hE: mode_exp = 4'h5;
            default: mode_exp = 4'hD;
        endcase
    endfunction
    // dividers held by sync keep the true clock low, so only inversion moves it
    task t_modes;
        logic [3:0] e;
        for (int inv = 0; inv < 2; inv++) begin
            for (int m = 0; m < 16; m++) begin
                e = mode_exp(m[3:0]);
                wr_reg(`CH_DRIVE_OFFSET, {inv[0], 3'h0, m[3:0]});
                repeat (3) @(posedge clk);
                #1 chk({oe_p[0], oe_n[0]}, e[3:2]);
                if (e[3]) chk(out_p[0], inv[0] ^ e[1]);
                if (e[2]) chk(out_n[0], inv[0] ^ e[0]);
                chk(diff_en[0], m >= 1 && m <= 5);
            end
        end
    endtask
    // channel 0 as a true clock; per 0 means no edge may come
    task t_div(input logic [9:0] s, input logic route, input logic v, input logic o, input int per);
        int base;
        wr_reg(`CH_DIV_LOW_OFFSET, s[7:0]);
        wr_reg(`CH_PHASE_DIV_HIGH_OFFSET, {6'h00, s[9:8]});
        wr_reg(`AUX_CHAN_CTRL_OFFSET, {7'h00, route});
        wr_reg(`CH_DRIVE_OFFSET, 8'h06);
        @(posedge clk);
        vt <= v;
        ot <= o;
        sync_hold <= 1'h0;
        // let edges from the old tick source drain out of the pin pipeline first
        repeat (3) @(posedge clk);
        #1 base = p0_edges;
        wait_edges(0, 3);
        if (per > 0) chk(p0_per, per);
        else chk(p0_edges - base, 0);
    endtask
    task t_phase;
        int lat, lat0;
        int ph[3] = '{0, 1, 63};
        // back to the running VCO ticks; the last divide scenario left the oscillator idle
        wr_reg(`AUX_CHAN_CTRL_OFFSET, 8'h00);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            sync_hold <= 1'h1;
            wr_reg(`CH_PHASE_DIV_HIGH_OFFSET, {ph[k][5:0], 2'h0});
            repeat (3) @(posedge clk);
            sync_hold <= 1'h0;
            lat = 0;
            while (out_p[0] !== 1'h1 && lat < 200) begin
                @(posedge clk);
                #1 lat++;
            end
            if (k == 0) lat0 = lat;
            else chk(lat, lat0 + ph[k]);
        end
    endtask
    task t_aux;
        logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        int base;
        @(posedge clk);
        ot <= 1'h1;
        for (int k = 0; k < 5; k++) begin
            wr_reg(`AUX_OUT_CTRL_OFFSET, {3'h0, k[0], codes[k]});
            wait_edges(1, 3);
            chk(ax_per, 2 << k);
            chk(aux_weak, k[0]);
        end
        // clock enable low freezes the divider and the pin, so no edge may come
        @(posedge clk);
        ce <= 1'h0;
        repeat (2) @(posedge clk);
        #1 base = ax_edges;
        repeat (40) @(posedge clk);
        #1 chk(ax_edges - base, 0);
        @(posedge clk);
        ce <= 1'h1;
        wr_reg(`AUX_CHAN_CTRL_OFFSET, 8'h80);
        repeat (4) @(posedge clk);
        #1 chk({aux_oe, aux_pin}, 2'h0);
        wr_reg(`AUX_CHAN_CTRL_OFFSET, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(aux_oe, 1'h1);
    endtask
    initial begin
        #400000;
        fail_count++;
        stop_test;
    end
    initial begin
        fail_count = 0;
        check_count = 0;
        resetn = 1'h0;
        ce = 1'h1;
        {wr, rd, ot} = 3'h0;
        {vt, sync_hold} = 2'h3;
        addr = 10'h000;
        wdata = 8'h00;
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        t_regs;
        t_modes;
        t_div(10'h000, 1'h0, 1'h1, 1'h0, 2);
        t_div(10'h004, 1'h0, 1'h1, 1'h0, 10);
        t_div(10'h3FF, 1'h0, 1'h1, 1'h0, 2048);
        t_div(10'h102, 1'h1, 1'h0, 1'h1, 518);
        t_div(10'h002, 1'h1, 1'h1, 1'h0, 0);
        t_phase;
        t_aux;
        stop_test;
    end
endmodule
`default_nettype wire
